//--- shared/ncs_pkg.sv
// Constants and types for the channel master-clock and NCO/spread block.
// Assumes a single 10 MHz system clock and software-driven control ports.
package ncs_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 10000000; // System clock rate.
	localparam int SS_RATE_MIN_HZ = 25000; // Slowest modulation rate.
	localparam int SS_RATE_MAX_HZ = 55000; // Fastest modulation rate.
	// Longest period rounds down, shortest rounds up.
	localparam int SS_PER_MAX = CLK_HZ / SS_RATE_MIN_HZ;
	localparam int SS_PER_MIN = (CLK_HZ + SS_RATE_MAX_HZ - 1) / SS_RATE_MAX_HZ;
	// ----------------------------------------
	// Field codes and reset values
	// ----------------------------------------
	localparam logic [1:0] XCFG_CRYSTAL = 2'h1; // Crystal driver on.
	localparam logic [1:0] XCFG_SINGLE = 2'h2; // Single-ended input.
	localparam logic [3:0] MODE_NCO = 4'h1; // Plain NCO.
	localparam logic [3:0] MODE_SPREAD = 4'h2; // Spread spectrum.
	localparam logic [1:0] MUX_NCO_TOP = 2'h3; // Upper select bits for NCO.
	localparam int LIM_NUM = 327; // About 0.499 % as LIM_NUM / 2^LIM_SHIFT.
	localparam int LIM_SHIFT = 16;
	localparam int WORD_BYTES = 5; // Bytes in the control word.
	localparam logic [2:0] LAST_BYTE = 3'h4; // Writing this byte commits.
	localparam int FW = 40; // Control word width.
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [0:0] {DIR_UP = 1'b0, DIR_DOWN = 1'b1} ncs_dir_e;
	// Byte write of the control word.
	typedef struct packed {
		logic wr;
		logic [2:0] idx;
		logic [7:0] data;
	} ncs_wr_s;
	// Whole state of the block.
	typedef struct packed {
		logic [31:0] shadow; // Low bytes waiting for commit.
		logic [FW-1:0] word; // Committed control word.
		logic [FW-1:0] lim; // Spread deviation ceiling.
		logic [FW-1:0] acc; // Phase accumulator.
		logic signed [FW:0] off; // Spread offset.
		logic [15:0] phase; // Position in modulation period.
		ncs_dir_e dir; // Triangle slope.
		logic xa_prev; // Previous master pin sample.
		logic use_xa; // Master clock taken from pin.
		logic nco_out; // Oscillator output.
	} ncs_state_s;
endpackage : ncs_pkg

//--- logic/ncs_core.sv
// Channel master-clock sourcing and NCO with triangle spread modulation.
// Assumes all pins are synchronous to clock_i; control bits come from ports.
// ----------------------------------------
// ----------------------------------------
module ncs_core
	import ncs_pkg::*;
#(
	parameter int WIDTH = FW,
	parameter logic [FW-1:0] NOMINAL = 40'h80_0000_0000
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic reset_n_i,
	// Master clock configuration.
	input wire logic [1:0] crystal_pin_config_i,
	input wire logic doubler_enable_i,
	input wire logic master_clock_select_i,
	input wire logic ring_osc_disable_i,
	input wire logic primary_crystal_pin_i,
	// Input receivers and shared pin.
	input wire logic [2:0] input_enable_reg_i,
	input wire logic third_input_pos_pin_i,
	input wire logic general_io_three_i,
	input wire logic general_io_three_dir_i,
	// Oscillator control.
	input wire logic nco_block_enable_i,
	input wire logic [3:0] nco_mode_i,
	input wire logic [2:0] pll_input_select_i,
	input wire ncs_wr_s freq_word_regs_i,
	input wire logic [FW-1:0] ss_step_i,
	input wire logic [15:0] ss_period_i,
	// Analog controls.
	output logic crystal_driver_en_o,
	output logic primary_single_en_o,
	output logic ring_osc_on_o,
	output logic regs_on_ring_o,
	output logic [2:0] receiver_en_o,
	// Shared pin.
	output logic general_io_three_o,
	output logic general_io_three_oe_n_o,
	output logic general_io_three_in_o,
	// Oscillator results.
	output logic pll_ref_is_nco_o,
	output logic pll_ref_o,
	output logic [FW-1:0] freq_control_word_o,
	output logic [FW-1:0] nominal_freq_word_o,
	output logic signed [FW:0] fractional_offset_o
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// A word below 37 bits cannot reach 0.01 ppb steps.
	if (WIDTH != FW || WIDTH < 37) begin : g_bad_width
		$error("ncs_core: WIDTH must equal the package word width");
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	ncs_state_s s; // Registered state.
	ncs_state_s next_s; // Next state.
	logic master_on; // Some master source powered.
	logic xa_now; // Gated primary pin.
	logic master_tick; // One master-clock event.
	logic run; // Oscillator active.
	logic spread; // Spread mode active.
	logic [FW-1:0] eff; // Word plus spread offset.
	logic [FW+8:0] lim_prod; // Deviation ceiling product.
	logic [FW-1:0] new_word; // Word after a commit.
	logic [15:0] per; // Clamped modulation period.

	// Tells whether a mode code means the oscillator is in use.
	function automatic logic mode_valid(input logic [3:0] m);
		return (m == MODE_NCO) || (m == MODE_SPREAD);
	endfunction : mode_valid

	// Pin configuration drives the analog enables directly.
	assign crystal_driver_en_o = (crystal_pin_config_i == XCFG_CRYSTAL);
	assign primary_single_en_o = (crystal_pin_config_i == XCFG_SINGLE);
	assign master_on = crystal_driver_en_o | primary_single_en_o;
	assign xa_now = master_on & primary_crystal_pin_i;
	// Ring oscillator powers down on the disable bit alone.
	assign ring_osc_on_o = ~ring_osc_disable_i;
	assign regs_on_ring_o = ~s.use_xa;
	// Receivers follow their own enable bit.
	assign receiver_en_o = input_enable_reg_i;
	// Third pin becomes GPIO only when its receiver is off.
	assign general_io_three_o = general_io_three_i;
	assign general_io_three_oe_n_o = input_enable_reg_i[2] | ~general_io_three_dir_i;
	assign general_io_three_in_o = input_enable_reg_i[2] ? 1'b0 : third_input_pos_pin_i;

	// Rising edge, or either edge with the doubler in the path.
	always_comb begin
		master_tick = xa_now & ~s.xa_prev;
		if (doubler_enable_i) begin
			master_tick = xa_now ^ s.xa_prev;
		end
	end

	assign run = nco_block_enable_i & s.use_xa & mode_valid(nco_mode_i);
	assign spread = run & (nco_mode_i == MODE_SPREAD);
	// The offset register may keep its last value for one cycle after spread ends.
	// Masking it here keeps a plain NCO step exact and the reported offset clean.
	assign eff = spread ? WIDTH'($signed({1'b0, s.word}) + s.off) : s.word;
	assign freq_control_word_o = s.word;
	assign nominal_freq_word_o = NOMINAL;
	// Zero when the committed word is the nominal one and no spread.
	assign fractional_offset_o = $signed({1'b0, eff}) - $signed({1'b0, NOMINAL});
	assign pll_ref_is_nco_o = (pll_input_select_i[2:1] == MUX_NCO_TOP);
	assign pll_ref_o = pll_ref_is_nco_o & s.nco_out;

	// Period held inside the legal modulation rate band.
	always_comb begin
		per = ss_period_i;
		if (ss_period_i < 16'(SS_PER_MIN)) begin
			per = 16'(SS_PER_MIN);
		end else if (ss_period_i > 16'(SS_PER_MAX)) begin
			per = 16'(SS_PER_MAX);
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Bytes 0 to 3 land in the shadow; the top byte commits the whole word.
	// The ceiling is worked out once per commit; in a commit cycle the wide product also feeds the sweep clamp.
	// Until the first commit after reset the ceiling is zero, so spreading then gives no deviation.
	always_comb begin
		next_s = s;
		new_word = {freq_word_regs_i.data, s.shadow};
		lim_prod = new_word * 9'(LIM_NUM);
		next_s.xa_prev = xa_now;
		// Switching to the pin needs the pin to be powered.
		next_s.use_xa = master_clock_select_i & master_on;
		if (freq_word_regs_i.wr) begin
			if (freq_word_regs_i.idx == LAST_BYTE) begin
				next_s.word = new_word;
				next_s.lim = WIDTH'(lim_prod >> LIM_SHIFT);
			end else if (freq_word_regs_i.idx < LAST_BYTE) begin
				next_s.shadow[freq_word_regs_i.idx*8 +: 8] = freq_word_regs_i.data;
			end
		end
		if (!run) begin
			next_s.acc = '0;
			next_s.nco_out = 1'b0;
		end else if (master_tick) begin
			next_s.acc = s.acc + eff;
			next_s.nco_out = s.acc[WIDTH-1];
		end
		if (!spread) begin
			next_s.off = '0;
			next_s.phase = '0;
			next_s.dir = DIR_UP;
		end else begin
			// Quarter one rises, half falls, last quarter rises back.
			// Turn points act one cycle late, so the sweep sits one step above center.
			next_s.phase = (s.phase >= per - 16'h0001) ? 16'h0000 : s.phase + 16'h0001;
			if (s.phase == (per >> 2)) begin
				next_s.dir = DIR_DOWN;
			end else if (s.phase == per - (per >> 2)) begin
				next_s.dir = DIR_UP;
			end
			case (s.dir)
				DIR_UP: begin
					next_s.off = s.off + $signed({1'b0, ss_step_i});
				end
				DIR_DOWN: begin
					next_s.off = s.off - $signed({1'b0, ss_step_i});
				end
				default: begin
					next_s.off = '0;
				end
			endcase
			// Clamp against the ceiling in force next cycle, so a commit that
			// shrinks the ceiling mid-sweep cannot leave the offset outside it.
			if (next_s.off > $signed({1'b0, next_s.lim})) begin
				next_s.off = $signed({1'b0, next_s.lim});
			end else if (next_s.off < -$signed({1'b0, next_s.lim})) begin
				next_s.off = -$signed({1'b0, next_s.lim});
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset returns to the ring oscillator and the nominal word.
	// Reset is synchronous, so the state is unknown until the first edge with it held low.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			s <= '{shadow: '0, word: NOMINAL, lim: '0, acc: '0, off: '0, phase: '0, dir: DIR_UP,
				xa_prev: 1'b0, use_xa: 1'b0, nco_out: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// A write of the top byte, the only event that may move the committed word.
	sequence top_byte_write;
		freq_word_regs_i.wr && freq_word_regs_i.idx == LAST_BYTE;
	endsequence

	// The commit takes the top byte and the shadow from the same edge.
	word_commit_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		top_byte_write |=> s.word == {$past(freq_word_regs_i.data), $past(s.shadow)})
		else $error("control word not committed whole");
	// Without a top byte the committed word holds.
	word_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!(freq_word_regs_i.wr && freq_word_regs_i.idx == LAST_BYTE) |=> $stable(s.word))
		else $error("control word changed without top byte");
	// Writes to byte numbers past the top are dropped whole.
	refused_idx_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		freq_word_regs_i.wr && freq_word_regs_i.idx > LAST_BYTE |=> $stable(s.shadow) && $stable(s.word))
		else $error("out of range byte changed the word");
	// Crystal setting alone turns the driver on, never with the single-ended path.
	driver_cfg_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		crystal_driver_en_o == (crystal_pin_config_i == 2'h1) && !(crystal_driver_en_o && primary_single_en_o))
		else $error("crystal driver enable wrong");
	// Power-down follows the disable bit.
	ring_off_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		ring_osc_disable_i |-> !ring_osc_on_o)
		else $error("ring oscillator not powered down");
	// Reset leaves the registers on the ring.
	ring_start_a: assert property (@(posedge clock_i)
		!reset_n_i |=> regs_on_ring_o)
		else $error("registers not on ring after reset");
	// An unpowered pin can never become the master.
	pin_power_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!master_on |=> regs_on_ring_o)
		else $error("master taken from unpowered pin");
	// Each receiver follows its own bit.
	rx_gate_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		receiver_en_o == input_enable_reg_i)
		else $error("receiver enable not its own bit");
	// With the third receiver on, the shared pin neither drives nor reads.
	gpio_free_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		input_enable_reg_i[2] |-> general_io_three_oe_n_o && !general_io_three_in_o)
		else $error("shared pin active while receiver on");
	// A disabled oscillator is cleared in one cycle.
	idle_clear_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!nco_block_enable_i |=> s.acc == '0 && !pll_ref_o)
		else $error("oscillator ran while disabled");
	// A plain NCO step adds exactly the committed word.
	nco_step_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		run && master_tick && !spread |=> s.acc == $past(s.acc) + $past(s.word))
		else $error("accumulator step wrong");
	// With the doubler every change of a powered pin is a master event.
	dbl_tick_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		doubler_enable_i && master_on && (primary_crystal_pin_i != s.xa_prev) |-> master_tick)
		else $error("doubler missed an edge");
	// The nominal word with no sweep reports no offset.
	nominal_zero_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		s.word == NOMINAL && s.off == '0 |-> fractional_offset_o == '0)
		else $error("nominal word shows offset");
	// Outside spread mode the offset is cleared in one cycle.
	spread_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!spread |=> s.off == '0)
		else $error("offset left over outside spread");
	// The sweep never leaves the deviation ceiling.
	spread_bound_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		spread |=> s.off <= $signed({1'b0, s.lim}) && s.off >= -$signed({1'b0, s.lim}))
		else $error("spread deviation beyond ceiling");
	// The sweep position never passes the longest legal period.
	phase_range_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		spread |=> s.phase < 16'(SS_PER_MAX))
		else $error("sweep position beyond period");
	// The oscillator reaches the reference under the matching select.
	mux_sel_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		pll_input_select_i[2:1] == 2'h3 && s.nco_out |-> pll_ref_o)
		else $error("mux did not pick oscillator");
	// Any other select keeps the oscillator off the reference.
	ref_gate_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		pll_input_select_i[2:1] != MUX_NCO_TOP |-> !pll_ref_o)
		else $error("oscillator on reference without select");
endmodule : ncs_core

//--- tb/ncs_xtal_model.sv
// External oscillator on the primary crystal pin.
// Assumes the bench clock; the pin toggles at a slow rate while powered and every cycle while unpowered.
module ncs_xtal_model #(
	parameter int HALF = 3
) (
	// Clock and pin power.
	input wire logic clock_i,
	input wire logic powered_i,
	// Pin level.
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0; // Cycles spent in this half period.
	initial pin_o = 1'b0;
	// An unpowered pin floats, so it shows a pattern that changes every cycle.
	always @(posedge clock_i) begin
		#1;
		if (!powered_i) begin
			pin_o = ~pin_o;
			cnt = 0;
		end else if (cnt == HALF - 1) begin
			pin_o = ~pin_o;
			cnt = 0;
		end else begin
			cnt = cnt + 1;
		end
	end
endmodule : ncs_xtal_model

//--- tb/tb_top.sv
// Self-checking bench for the master-clock and NCO/spread block.
// Assumes the design and its package are compiled first.
module tb_top;
	import ncs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [FW-1:0] NOM = 40'h80_0000_0000; // Nominal word at the design's default.
	localparam logic [FW-1:0] W1 = 40'h80_0123_4567; // A small positive offset.
	logic clock_i = 1'b0, reset_n_i = 1'b0, doubler_enable = 1'b0, msel = 1'b0, rdis = 1'b0, pin;
	logic tpin = 1'b1, gout = 1'b1, gdir = 1'b1, nen = 1'b0;
	logic [1:0] cfg = 2'h0;
	logic [2:0] input_enable_reg = 3'h0, psel = 3'h0, rxen;
	logic [3:0] mode = 4'h0;
	ncs_wr_s wr = '0;
	logic [FW-1:0] step = 40'h00_0040_0000, fcw, nomw; // Sweep peak stays inside 500 ppm.
	logic [15:0] per = 16'h00C8;
	logic xdrv, xse, ron, rring, gio, goe_n, gin, isnco, pref;
	logic signed [FW:0] fractional_offset;
	longint mx, mn, lim;
	int n_fail = 0, n_checks = 0, r0, r1, r2;
	// ----------------------------------------
	// Design and far-side oscillator
	// ----------------------------------------
	ncs_core u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .crystal_pin_config_i(cfg),
		.doubler_enable_i(doubler_enable), .master_clock_select_i(msel), .ring_osc_disable_i(rdis),
		.primary_crystal_pin_i(pin), .input_enable_reg_i(input_enable_reg), .third_input_pos_pin_i(tpin),
		.general_io_three_i(gout), .general_io_three_dir_i(gdir), .nco_block_enable_i(nen),
		.nco_mode_i(mode), .pll_input_select_i(psel), .freq_word_regs_i(wr), .ss_step_i(step),
		.ss_period_i(per), .crystal_driver_en_o(xdrv), .primary_single_en_o(xse),
		.ring_osc_on_o(ron), .regs_on_ring_o(rring), .receiver_en_o(rxen),
		.general_io_three_o(gio), .general_io_three_oe_n_o(goe_n), .general_io_three_in_o(gin),
		.pll_ref_is_nco_o(isnco), .pll_ref_o(pref), .freq_control_word_o(fcw),
		.nominal_freq_word_o(nomw), .fractional_offset_o(fractional_offset));
	ncs_xtal_model #(.HALF(3)) u_xtal (.clock_i(clock_i), .powered_i(xdrv | xse), .pin_o(pin));
	// Free-running 10 MHz clock.
	always #50 clock_i = ~clock_i;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Every stimulus change lands one nanosecond after a rising edge.
	task tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : tick
	task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// The strobe stays high between bytes so it is never assigned twice in one step.
	task put(input logic [2:0] i, input logic [7:0] d);
		wr = '{1'b1, i, d};
		tick(1);
	endtask : put
	task commit(input logic [FW-1:0] w);
		for (int i = 0; i < WORD_BYTES; i++) put(3'(i), w[8*i +: 8]);
		wr = '0;
		tick(1);
	endtask : commit
	// Counts reference rises over a fixed window of 120 cycles.
	task rises(output int r);
		logic prev;
		r = 0;
		prev = pref;
		repeat (120) begin
			tick(1);
			if (pref === 1'b1 && prev === 1'b0) r++;
			prev = pref;
		end
	endtask : rises
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test
	// Watchdog at 10000 cycles: the whole sequence needs well under 2000 cycles.
	initial begin
		#1000000;
		n_fail++;
		finish_test();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		tick(10);
		reset_n_i = 1'b1;
		tick(1);
		chk("ring_after_reset", rring, 1);
		chk("word_reset", fcw, NOM);
		chk("offset_reset", fractional_offset, 0);
		chk("nominal", nomw, NOM);
		for (int c = 0; c < 4; c++) begin
			cfg = 2'(c);
			rdis = c[0];
			tick(1);
			chk("xtal_drv", xdrv, cfg == XCFG_CRYSTAL);
			chk("single_en", xse, cfg == XCFG_SINGLE);
			chk("ring_on", ron, !rdis);
		end
		rdis = 1'b0;
		for (int v = 0; v < 8; v++) begin
			input_enable_reg = 3'(v);
			psel = 3'(v);
			tick(1);
			chk("rx_en", rxen, input_enable_reg);
			chk("ref_is_nco", isnco, psel[2:1] == MUX_NCO_TOP);
			chk("gpio_oe_n", goe_n, input_enable_reg[2]);
			chk("gpio_in", gin, ~input_enable_reg[2] & tpin);
		end
		chk("gpio_out", gio, gout);
		gout = 1'b0;
		gdir = 1'b0;
		input_enable_reg = 3'h0;
		tick(1);
		chk("gpio_out_low", gio, 0);
		chk("gpio_oe_n_in", goe_n, 1);
		cfg = 2'h0;
		msel = 1'b1;
		tick(3);
		chk("select_unpowered", rring, 1);
		cfg = XCFG_CRYSTAL;
		tick(2);
		chk("select_powered", rring, 0);
		for (int i = 0; i < 4; i++) put(3'(i), W1[8*i +: 8]);
		wr = '0;
		tick(1);
		chk("partial_word", fcw, NOM);
		put(3'h5, 8'hFF);
		put(LAST_BYTE, W1[39:32]);
		wr = '0;
		tick(1);
		chk("word_commit", fcw, W1);
		chk("offset_word", fractional_offset, 64'(W1) - 64'(NOM));
		commit(NOM);
		psel = 3'h6;
		mode = MODE_NCO;
		nen = 1'b1;
		rises(r0);
		chk("nco_runs", r0 > 0, 1);
		doubler_enable = 1'b1;
		rises(r1);
		chk("doubler_faster", r1 > r0, 1);
		cfg = XCFG_SINGLE;
		rises(r2);
		chk("doubler_single", r2 > r0, 1);
		nen = 1'b0;
		tick(3);
		chk("disabled_ref", pref, 0);
		mode = MODE_SPREAD;
		nen = 1'b1;
		mx = 0;
		mn = 0;
		lim = (longint'(NOM) * LIM_NUM) >>> LIM_SHIFT;
		repeat (400) begin
			tick(1);
			if (longint'(fractional_offset) > mx) mx = longint'(fractional_offset);
			if (longint'(fractional_offset) < mn) mn = longint'(fractional_offset);
		end
		chk("spread_up", mx > 0, 1);
		chk("spread_down", mn < 0, 1);
		chk("spread_limit", mx <= lim && -mn <= lim, 1);
		finish_test();
	end
endmodule : tb_top
